/* File: hdl/erm_pkg.sv */
// Package: constants and types for the ECC read-merge-write block
package erm_pkg;
    localparam int DATA_W = 64;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 32;
    localparam int BYTES = 8;
    localparam logic [BYTES-1:0] FULL_MASK = 8'hff;
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    typedef enum logic [2:0] {
        ERM_IDLE,
        ERM_WR,
        ERM_RD_REQ,
        ERM_RD_WAIT,
        ERM_MERGE,
        ERM_RD_HOST,
        ERM_DONE
    } erm_state_t;
endpackage

/* File: hdl/erm_ecc_rmw.sv */
// Module: ECC encode, check, correct and read-merge-write sequencer
// What this block does
// - ECC behaviour only while the enable is set
// - Eight-bit check code per 64-bit quadword
// - Every ECC write is a full quadword plus code
// - Partial writes become read-merge-write sequences
// - Read quadword, merge bytes, recode, write back
// - Correct single-bit read error before the merge
// - Correct single-bit data errors, flag check-bit flips and double-bit errors as uncorrectable
`timescale 1ns/100ps
module erm_ecc_rmw (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ecc_enable,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [31:0] host_addr,
    input wire logic [63:0] host_wdata,
    input wire logic [7:0] host_be,
    output logic host_ready,
    output logic host_done,
    output logic [63:0] host_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [63:0] mem_wdata,
    output logic [7:0] mem_wcode,
    output logic [7:0] mem_be,
    input wire logic mem_ack,
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    input wire logic [7:0] mem_rcode,
    output logic err_corrected,
    output logic err_uncorrectable
);

    ////////////////////////////////////////////////////////////////////////
    // Odd-weight columns: data bits 0 to 55 take the three-of-eight columns in
    // order, bits 56 to 63 the five-of-eight complements of the first eight.
    // Every single flip then gives an odd syndrome and every double an even one.
    localparam int unsigned TRIPLES = 56;

    function automatic logic [7:0] col_of(input int unsigned k);
        logic [7:0] c;
        int unsigned n;
        int unsigned j;
        c = 8'h00;
        n = 0;
        j = (k < TRIPLES) ? k : k - TRIPLES;
        for (int a = 0; a < 8; a++) begin
            for (int b = a + 1; b < 8; b++) begin
                for (int d = b + 1; d < 8; d++) begin
                    if (n == j) begin
                        c = 8'h00;
                        c[a] = 1'b1;
                        c[b] = 1'b1;
                        c[d] = 1'b1;
                    end
                    n++;
                end
            end
        end
        if (k >= TRIPLES) begin
            c = ~c;
        end
        return c;
    endfunction

    function automatic logic [7:0] encode(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < 64; k++) begin
            if (d[k]) begin
                c = c ^ col_of(k);
            end
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Syndrome decode of the read quadword
    logic [7:0] syndrome;
    logic [63:0] flip;
    logic [63:0] corr_data;
    logic single_err;
    logic multi_err;

    assign syndrome = encode(mem_rdata) ^ mem_rcode;

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_flip
            assign flip[g] = (syndrome == col_of(g));
        end
    endgenerate

    assign corr_data = mem_rdata ^ flip;
    // Odd syndrome matching a column: one data bit flipped, corrected in place.
    // Any other nonzero syndrome, a lone check-bit flip included, is reported
    // as uncorrectable and the data passes through unchanged.
    assign single_err = (syndrome != 8'h00) && ^syndrome;
    assign multi_err = (syndrome != 8'h00) && !(^syndrome && (flip != 64'h0));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    erm_pkg::erm_state_t state_r;
    logic [31:0] addr_r;
    logic [63:0] wdata_r;
    logic [7:0] be_r;
    logic [63:0] merge_r;
    logic ecc_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= erm_pkg::ERM_IDLE;
        end else begin
            case (state_r)
                erm_pkg::ERM_IDLE: begin
                    // Partial writes in ECC mode fetch the quadword first
                    if (host_req && host_we && ecc_enable && host_be != erm_pkg::FULL_MASK)
                        state_r <= erm_pkg::ERM_RD_REQ;
                    else if (host_req && host_we)
                        state_r <= erm_pkg::ERM_WR;
                    else if (host_req)
                        state_r <= erm_pkg::ERM_RD_HOST;
                end
                erm_pkg::ERM_RD_REQ: begin
                    if (mem_ack)
                        state_r <= erm_pkg::ERM_RD_WAIT;
                end
                erm_pkg::ERM_RD_WAIT: begin
                    if (mem_rvalid)
                        state_r <= erm_pkg::ERM_MERGE;
                end
                erm_pkg::ERM_MERGE: state_r <= erm_pkg::ERM_WR;
                erm_pkg::ERM_WR: begin
                    if (mem_ack)
                        state_r <= erm_pkg::ERM_DONE;
                end
                erm_pkg::ERM_RD_HOST: begin
                    if (mem_rvalid)
                        state_r <= erm_pkg::ERM_DONE;
                end
                erm_pkg::ERM_DONE: state_r <= erm_pkg::ERM_IDLE;
                default: state_r <= erm_pkg::ERM_IDLE;
            endcase
        end
    end

    // Request capture; mode is latched per request so it cannot change mid-sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_r <= erm_pkg::ADDR_RST;
            wdata_r <= erm_pkg::DATA_RST;
            be_r <= 8'h00;
            ecc_r <= 1'b0;
        end else if (state_r == erm_pkg::ERM_IDLE && host_req) begin
            addr_r <= host_addr;
            wdata_r <= host_wdata;
            be_r <= host_be;
            ecc_r <= ecc_enable;
        end
    end

    // Merge of new bytes over the corrected read quadword
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            merge_r <= erm_pkg::DATA_RST;
        end else if (state_r == erm_pkg::ERM_RD_WAIT && mem_rvalid) begin
            for (int i = 0; i < 8; i++) begin
                merge_r[i*8 +: 8] <= be_r[i] ? wdata_r[i*8 +: 8] : corr_data[i*8 +: 8];
            end
        end else if (state_r == erm_pkg::ERM_IDLE && host_req) begin
            merge_r <= host_wdata;
        end
    end

    // Read data returned to the host, corrected when ECC is on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            host_rdata <= erm_pkg::DATA_RST;
        end else if (state_r == erm_pkg::ERM_RD_HOST && mem_rvalid) begin
            host_rdata <= ecc_r ? corr_data : mem_rdata;
        end
    end

    // Error event pulses, at most one per checked read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            err_corrected <= 1'b0;
            err_uncorrectable <= 1'b0;
        end else begin
            err_corrected <= ecc_r && mem_rvalid && single_err && (flip != 64'h0)
                && (state_r == erm_pkg::ERM_RD_WAIT || state_r == erm_pkg::ERM_RD_HOST);
            err_uncorrectable <= ecc_r && mem_rvalid && multi_err
                && (state_r == erm_pkg::ERM_RD_WAIT || state_r == erm_pkg::ERM_RD_HOST);
        end
    end

    // Memory port: full quadword with code in ECC mode
    // Direct writes take their code on acceptance, merged ones in the merge cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_wcode <= erm_pkg::CODE_RST;
        end else if (state_r == erm_pkg::ERM_MERGE ||
                     (state_r == erm_pkg::ERM_IDLE && host_req)) begin
            mem_wcode <= encode(state_r == erm_pkg::ERM_MERGE ? merge_r : host_wdata);
        end
    end

    // Handshake and memory strobes decode the state directly
    assign mem_req = (state_r == erm_pkg::ERM_WR) || (state_r == erm_pkg::ERM_RD_REQ)
        || (state_r == erm_pkg::ERM_RD_HOST);
    assign mem_we = (state_r == erm_pkg::ERM_WR);
    assign mem_addr = addr_r;
    assign mem_wdata = merge_r;
    assign mem_be = ecc_r ? erm_pkg::FULL_MASK : be_r;
    assign host_ready = (state_r == erm_pkg::ERM_IDLE);
    assign host_done = (state_r == erm_pkg::ERM_DONE);

endmodule

/* File: tb/erm_ecc_rmw_checker.sv */
// Checker: port-level properties of the ECC read-merge-write block
`timescale 1ns/100ps
module erm_ecc_rmw_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ecc_enable,
    input wire logic host_req,
    input wire logic host_ready,
    input wire logic host_we,
    input wire logic host_done,
    input wire logic [7:0] host_be,
    input wire logic [7:0] mem_be,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_ack,
    input wire logic mem_rvalid,
    input wire logic err_corrected,
    input wire logic err_uncorrectable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire take = host_req && host_ready && ecc_enable && host_we;
    logic take_ecc_r;
    logic [7:0] take_be_r;
    // Mode and byte mask as the block latched them when it took the request
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            take_ecc_r <= 1'b0;
            take_be_r <= 8'h00;
        end else if (host_req && host_ready) begin
            take_ecc_r <= ecc_enable;
            take_be_r <= host_be;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    be_full_a: assert property (mem_req && take_ecc_r |-> mem_be == 8'hff)
        else $error("ECC mode request without a full byte mask");
    be_pass_a: assert property (mem_req && !take_ecc_r |-> mem_be == take_be_r)
        else $error("Byte mask altered with ECC mode off");
    rmw_read_a: assert property (take && host_be != 8'hff |=> mem_req && !mem_we)
        else $error("Partial ECC write did not start with a read");
    full_wr_a: assert property (take && host_be == 8'hff |=> mem_req && mem_we)
        else $error("Full ECC write did not go straight to memory");
    merge_wr_a: assert property (mem_rvalid && !mem_req |-> ##2 mem_req && mem_we)
        else $error("Merged quadword not written back");
    flag_off_a: assert property (!take_ecc_r |-> !err_corrected && !err_uncorrectable)
        else $error("Error flag raised with ECC mode off");
    flag_excl_a: assert property (!(err_corrected && err_uncorrectable))
        else $error("Both error flags raised together");
    flag_cause_a: assert property (err_corrected || err_uncorrectable |-> $past(mem_rvalid))
        else $error("Error flag without a preceding read");
    wr_done_a: assert property (mem_ack && mem_we |=> host_done)
        else $error("Accepted write not completed");
    done_idle_a: assert property (host_done |=> host_ready && !mem_req)
        else $error("Block not idle after completion");
    cover property (take && host_be != 8'hff);
    cover property (take && host_be == 8'hff);
    cover property (err_corrected);
    cover property (err_uncorrectable);
endmodule
bind erm_ecc_rmw erm_ecc_rmw_checker u_chk (.*);

/* File: tb/erm_mem_model.sv */
// Partner model: behavioural quadword memory with read-path bit flip injection
`timescale 1ns/100ps
module erm_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [63:0] mem_wdata,
    input wire logic [63:0] flip,
    input wire logic [7:0] mem_wcode,
    input wire logic [7:0] mem_be,
    output logic mem_ack,
    output logic mem_rvalid,
    output logic [63:0] mem_rdata,
    output logic [7:0] mem_rcode
);
    logic [63:0] mem_d [16];
    logic [7:0] mem_c [16];
    logic [1:0] ph_r;
    wire [3:0] a = mem_addr[6:3];
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph_r <= 2'h0;
            mem_ack <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= '0;
            mem_rcode <= '0;
        end else begin
            mem_ack <= 1'b0;
            mem_rvalid <= 1'b0;
            // Bus not valid: toggle so stale data never looks good
            mem_rdata <= ~mem_rdata;
            mem_rcode <= ~mem_rcode;
            if (ph_r != 2'h0) begin
                ph_r <= ph_r + 2'h1;
            end
            if (ph_r == 2'h1) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= mem_d[a] ^ flip;
                mem_rcode <= mem_c[a];
            end else if (ph_r == 2'h0 && mem_req && !mem_ack) begin
                mem_ack <= 1'b1;
                if (mem_we) begin
                    for (int i = 0; i < 8; i++) begin
                        if (mem_be[i]) begin
                            mem_d[a][8*i +: 8] <= mem_wdata[8*i +: 8];
                        end
                    end
                    mem_c[a] <= mem_wcode;
                end else begin
                    ph_r <= 2'h1;
                end
            end
        end
    end
endmodule

/* File: tb/test_erm_ecc_rmw.sv */
// Testbench: ECC write, read-merge-write, correction and bypass scenarios
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_erm_ecc_rmw;
    logic core_clk = 0, rst = 1, ecc_enable = 1, host_req = 0, host_we = 0, sc, su;
    logic [31:0] host_addr = '0, mem_addr;
    logic [63:0] host_wdata = '0, host_rdata, mem_wdata, mem_rdata, flip = '0;
    logic [7:0] host_be = '0, mem_wcode, mem_be, mem_rcode;
    logic host_ready, host_done, mem_req, mem_we, mem_ack, mem_rvalid;
    logic err_corrected, err_uncorrectable;
    int err_count = 0, cmp_count = 0;
    always #2.5 core_clk = ~core_clk;
    // Flags seen since the block took the current request
    always @(posedge core_clk) begin
        if (host_req && host_ready) begin
            sc <= 1'b0;
            su <= 1'b0;
        end else begin
            if (err_corrected) sc <= 1'b1;
            if (err_uncorrectable) su <= 1'b1;
        end
    end
    erm_ecc_rmw DUT (.*);
    erm_mem_model u_mem (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic op(input logic we, input logic [7:0] ad, input logic [63:0] d,
                      input logic [7:0] be);
        host_req = 1'b1;
        host_we = we;
        host_addr = 32'(ad);
        host_wdata = d;
        host_be = be;
        @(posedge core_clk);
        #1 host_req = 1'b0;
        for (int n = 0; n < 40 && host_done !== 1'b1; n++) @(posedge core_clk) #1;
        `CHK("done", 1'b1, host_done)
        @(posedge core_clk) #1;
    endtask
    task automatic t_full();
        op(1'b1, 8'h08, 64'h0123_4567_89ab_cdef, 8'hff);
        op(1'b0, 8'h08, '0, 8'hff);
        `CHK("rdata", 64'h0123_4567_89ab_cdef, host_rdata)
        `CHK("flags", 2'h0, {sc, su})
    endtask
    task automatic t_rmw();
        op(1'b1, 8'h08, 64'h5555_5555_aaaa_aaaa, 8'h0f);
        op(1'b0, 8'h08, '0, 8'hff);
        `CHK("merge", 64'h0123_4567_aaaa_aaaa, host_rdata)
        `CHK("flags", 2'h0, {sc, su})
    endtask
    task automatic t_fix();
        flip = 64'h0000_0000_0000_0010;
        op(1'b1, 8'h08, 64'h9999_9999_0000_0000, 8'hf0);
        `CHK("fixflag", 2'h2, {sc, su})
        flip = '0;
        op(1'b0, 8'h08, '0, 8'hff);
        `CHK("fixdata", 64'h9999_9999_aaaa_aaaa, host_rdata)
        `CHK("clean", 2'h0, {sc, su})
        flip = 64'h8000_0000_0000_0000;
        op(1'b0, 8'h08, '0, 8'hff);
        `CHK("corr", 64'h9999_9999_aaaa_aaaa, host_rdata)
        `CHK("sbe", 2'h2, {sc, su})
        flip = 64'h0000_0000_0000_0003;
        op(1'b0, 8'h08, '0, 8'hff);
        `CHK("dbe", 2'h1, {sc, su})
        flip = '0;
    endtask
    task automatic t_off();
        ecc_enable = 1'b0;
        op(1'b1, 8'h10, 64'h1111_2222_3333_4444, 8'hff);
        op(1'b1, 8'h10, 64'h5555_5555_5555_5555, 8'h03);
        flip = 64'h0000_0000_0001_0000;
        op(1'b0, 8'h10, '0, 8'hff);
        `CHK("raw", 64'h1111_2222_3332_5555, host_rdata)
        `CHK("noflag", 2'h0, {sc, su})
    endtask
    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        t_full();
        t_rmw();
        t_fix();
        t_off();
        end_sim();
    end
    initial begin
        #20000;
        err_count++;
        end_sim();
    end
endmodule
